// ### adcp_port.sv
// Purpose: control-word port and sample queue front end of a four-input sampling converter
// Assumes: clk_in at 10 MHz, bus pins and the sample clock pin are asynchronous to it
// Notes: the analog result arrives on sample_value_in for the source on analog_select_out
`timescale 1ns/100ps

package adcp_pkg;
  localparam int unsigned CR_W = 10;
  localparam int unsigned DATA_W = 10;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_CNT_W = 3;
  localparam int unsigned SIZE_W = 5;

  localparam logic [1:0] ADDR_CR0 = 2'h0;
  localparam logic [1:0] ADDR_CR1 = 2'h1;

  localparam int CR0_VREF = 0;
  localparam int CR0_MODE = 1;
  localparam int CR0_SLEEP = 2;
  localparam int CR0_PICK_LO = 3;
  localparam int CR0_SCAN = 7;
  localparam int CR0_CHECK_LO = 8;
  localparam logic [CR_W-1:0] CR0_RESET = 10'h020;

  localparam int CR1_SOFT_RST = 0;
  localparam int CR1_QCLR = 1;
  localparam int CR1_SIZE_LO = 2;
  localparam int CR1_AV_TYPE = 4;
  localparam int CR1_AV_POL = 5;
  localparam int CR1_RW = 6;
  localparam int CR1_FMT = 7;
  localparam int CR1_OFFSET = 8;
  localparam logic [CR_W-1:0] CR1_RESET = 10'h000;
  localparam logic [CR_W-1:0] CR1_STORE_MASK = 10'h1FC;

  localparam int PIN_SCLK = 0;
  localparam int PIN_WR_N = 1;
  localparam int PIN_RD_N = 2;
  localparam int PIN_CS_HI = 3;
  localparam int PIN_CS_LO_N = 4;
  localparam int PIN_RA_LO = 5;
  localparam int PIN_RA_HI = 6;
  localparam int PIN_D_LO = 7;
  localparam int unsigned SYNC_W = 17;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 17'h0_0017;

  localparam logic [SIZE_W-1:0] LAT_BASE = 5'h08;
  localparam logic [SIZE_W-1:0] SIZE_1 = 5'h01;
  localparam logic [SIZE_W-1:0] SIZE_4 = 5'h04;
  localparam logic [SIZE_W-1:0] SIZE_8 = 5'h08;
  localparam logic [SIZE_W-1:0] SIZE_14 = 5'h0E;

  localparam logic [1:0] CHECK_NORMAL = 2'h0;
  localparam logic [1:0] CHECK_UPPER = 2'h1;
  localparam logic [1:0] CHECK_MID = 2'h2;
  localparam logic [DATA_W-1:0] CODE_UPPER = 10'h3FF;
  localparam logic [DATA_W-1:0] CODE_MID = 10'h200;
  localparam logic [DATA_W-1:0] CODE_LOWER = 10'h000;

  typedef enum logic [2:0] {
    SRC_A_PLUS, SRC_A_MINUS, SRC_B_PLUS, SRC_B_MINUS, SRC_DIFF_A, SRC_DIFF_B
  } adcp_src_t;

  typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} adcp_state_t;

  // cfg is {scan, pair_count_hi, pair_count_lo, input_pick_hi, input_pick_lo}
  function automatic logic [1:0] seq_last(input logic [4:0] cfg);
    case (cfg)
      5'h11: seq_last = 2'h1;
      5'h12: seq_last = 2'h2;
      5'h13: seq_last = 2'h3;
      5'h15: seq_last = 2'h1;
      5'h16: seq_last = 2'h2;
      5'h19: seq_last = 2'h1;
      default: seq_last = 2'h0;
    endcase
  endfunction

  function automatic adcp_src_t seq_src(input logic [4:0] cfg, input logic [1:0] step);
    case (cfg)
      5'h00: seq_src = SRC_A_PLUS;
      5'h01: seq_src = SRC_A_MINUS;
      5'h02: seq_src = SRC_B_PLUS;
      5'h03: seq_src = SRC_B_MINUS;
      5'h04: seq_src = SRC_DIFF_A;
      5'h05: seq_src = SRC_DIFF_B;
      5'h11, 5'h12, 5'h13: begin
        case (step)
          2'h0: seq_src = SRC_A_PLUS;
          2'h1: seq_src = SRC_A_MINUS;
          2'h2: seq_src = SRC_B_PLUS;
          default: seq_src = SRC_B_MINUS;
        endcase
      end
      5'h15: seq_src = (step == 2'h0) ? SRC_A_PLUS : SRC_DIFF_B;
      5'h16: begin
        case (step)
          2'h0: seq_src = SRC_A_PLUS;
          2'h1: seq_src = SRC_A_MINUS;
          default: seq_src = SRC_DIFF_B;
        endcase
      end
      5'h19: seq_src = (step == 2'h0) ? SRC_DIFF_A : SRC_DIFF_B;
      default: seq_src = SRC_A_PLUS;
    endcase
  endfunction

  function automatic logic [SIZE_W-1:0] block_size(input logic [1:0] code);
    case (code)
      2'h0: block_size = SIZE_1;
      2'h1: block_size = SIZE_4;
      2'h2: block_size = SIZE_8;
      default: block_size = SIZE_14;
    endcase
  endfunction
endpackage

module adcp_port
  import adcp_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [DATA_W-1:0] bus_data_in,
  output logic [DATA_W-1:0] bus_data_out,
  output logic bus_data_oe_n_out,
  input wire logic reg_addr_bit_lo_in,
  input wire logic reg_addr_bit_hi_in,
  input wire logic chip_select_low_active_n_in,
  input wire logic chip_select_high_active_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  input wire logic sample_clock_in,
  output logic samples_waiting_n_out,
  input wire logic [DATA_W-1:0] sample_value_in,
  output logic [2:0] analog_select_out,
  output logic hold_pulse_out,
  output logic ref_external_out,
  output logic sleep_request_out,
  output logic [1:0] check_sel_out,
  output logic output_code_format_out,
  output logic offset_enable_out,
  output logic rw_pin_mode_out,
  output logic overflow_out
);

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, a bit moves once stages 2 and 3 agree
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic [SYNC_W-1:0] pin_r;
  logic [SYNC_W-1:0] pin_prev_r;
  wire [SYNC_W-1:0] pin_raw = {bus_data_in, reg_addr_bit_hi_in, reg_addr_bit_lo_in,
                               chip_select_low_active_n_in, chip_select_high_active_in,
                               read_n_in, write_n_in, sample_clock_in};
  wire [SYNC_W-1:0] agree = s2_r ~^ s3_r;
  wire [SYNC_W-1:0] pin_nxt = (agree & s3_r) | (~agree & pin_r);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_r <= SYNC_RESET;
      s2_r <= SYNC_RESET;
      s3_r <= SYNC_RESET;
      pin_r <= SYNC_RESET;
      pin_prev_r <= SYNC_RESET;
    end else if (ce_in) begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= pin_nxt;
      pin_prev_r <= pin_r;
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [CR_W-1:0] cr0_r;
  logic [CR_W-1:0] cr1_r;
  logic write_prev_r;
  logic read_prev_r;
  wire cs_active = ~pin_r[PIN_CS_LO_N] & pin_r[PIN_CS_HI];
  wire read_strobe = cs_active & ~pin_r[PIN_RD_N];
  wire write_strobe = cs_active & ~pin_r[PIN_WR_N];
  // data and address are taken from the cycle before the strobe ends, still inside it
  wire write_done = write_prev_r & ~write_strobe;
  wire [1:0] addr_prev = {pin_prev_r[PIN_RA_HI], pin_prev_r[PIN_RA_LO]};
  wire [CR_W-1:0] bus_word = pin_prev_r[PIN_D_LO +: CR_W];
  wire wr_cr0 = write_done & (addr_prev == ADDR_CR0);
  wire wr_cr1 = write_done & (addr_prev == ADDR_CR1);
  wire soft_rst = wr_cr1 & bus_word[CR1_SOFT_RST];
  wire queue_clear = soft_rst | (wr_cr1 & bus_word[CR1_QCLR]);
  wire read_begin = read_strobe & ~read_prev_r;
  wire read_done = read_prev_r & ~read_strobe;

  // ----------------------------------------------------------------
  // control words
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cr0_r <= CR0_RESET;
      cr1_r <= CR1_RESET;
    end else if (ce_in) begin
      if (soft_rst) begin
        cr0_r <= CR0_RESET;
        cr1_r <= CR1_RESET;
      end else begin
        if (wr_cr0) begin
          cr0_r <= bus_word;
        end
        if (wr_cr1) begin
          // reset and clear bits act once and are not kept, bit 9 stays zero
          cr1_r <= bus_word & CR1_STORE_MASK;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  wire awake = ~cr0_r[CR0_SLEEP];
  wire single_mode = cr0_r[CR0_MODE];
  wire [4:0] scan_cfg = cr0_r[CR0_SCAN:CR0_PICK_LO];
  wire [1:0] check_sel = cr0_r[CR0_CHECK_LO +: 2];
  wire [SIZE_W-1:0] size = block_size(cr1_r[CR1_SIZE_LO +: 2]);
  wire [SIZE_W-1:0] lat_target = SIZE_W'(LAT_BASE + size);
  wire [1:0] last_step = seq_last(scan_cfg);

  assign ref_external_out = cr0_r[CR0_VREF];
  assign sleep_request_out = cr0_r[CR0_SLEEP];
  assign check_sel_out = check_sel;
  assign output_code_format_out = cr1_r[CR1_FMT];
  assign offset_enable_out = cr1_r[CR1_OFFSET];
  assign rw_pin_mode_out = cr1_r[CR1_RW];

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  adcp_state_t state_r;
  logic [1:0] step_r;
  logic [SIZE_W-1:0] lat_cnt_r;
  logic [SIZE_W-1:0] blk_cnt_r;
  logic hold_r;
  adcp_src_t src_r;
  logic overflow_r;
  logic av_pulse_r;
  logic av_n_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic [FIFO_CNT_W-1:0] fifo_count;

  wire sclk_fall = pin_prev_r[PIN_SCLK] & ~pin_r[PIN_SCLK];
  wire lat_done = (lat_cnt_r >= lat_target);
  wire cont_edge = ~single_mode & awake & sclk_fall;
  wire lat_step = cont_edge & ~lat_done;
  wire cont_push = cont_edge & lat_done;
  wire single_push = (state_r == ST_CONVERT);
  // single mode waits for room, continuous mode cannot and drops the value instead
  wire step_go = cont_push | (single_push & fifo_in_ready);
  wire push_req = cont_push | single_push;
  wire push_fire = push_req & fifo_in_ready;
  wire drop = cont_push & ~fifo_in_ready;
  wire start = single_mode & awake & sclk_fall & (state_r == ST_IDLE);
  wire [1:0] step_nxt = (step_r == last_step) ? 2'h0 : 2'(step_r + 2'h1);
  adcp_src_t cur_src;
  assign cur_src = seq_src(scan_cfg, step_r);

  // test levels replace the input value, format bit flips the sign bit
  wire [DATA_W-1:0] raw_value = (check_sel == CHECK_NORMAL) ? sample_value_in :
                                (check_sel == CHECK_UPPER) ? CODE_UPPER :
                                (check_sel == CHECK_MID) ? CODE_MID : CODE_LOWER;
  wire [DATA_W-1:0] push_value = cr1_r[CR1_FMT] ?
                                 {~raw_value[DATA_W-1], raw_value[DATA_W-2:0]} : raw_value;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_r <= ST_IDLE;
      step_r <= 2'h0;
      lat_cnt_r <= '0;
      hold_r <= 1'b0;
      src_r <= SRC_A_PLUS;
    end else if (ce_in) begin
      hold_r <= start;
      src_r <= cur_src;
      if (queue_clear | wr_cr0) begin
        state_r <= ST_IDLE;
        step_r <= 2'h0;
        if (queue_clear) begin
          lat_cnt_r <= '0;
        end
      end else begin
        if (lat_step) begin
          lat_cnt_r <= SIZE_W'(lat_cnt_r + 1'b1);
        end
        case (state_r)
          ST_IDLE: begin
            if (start) begin
              state_r <= ST_CONVERT;
              step_r <= 2'h0;
            end else if (step_go) begin
              step_r <= step_nxt;
            end
          end
          ST_CONVERT: begin
            if (~awake) begin
              state_r <= ST_IDLE;
              step_r <= 2'h0;
            end else if (step_go) begin
              step_r <= step_nxt;
              if (step_r == last_step) begin
                state_r <= ST_IDLE;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign analog_select_out = src_r;
  assign hold_pulse_out = hold_r;

  // ----------------------------------------------------------------
  // sample queue
  // ----------------------------------------------------------------
  adcp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .CNT_W(FIFO_CNT_W)
  ) u_fifo (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .clear_in(queue_clear),
    .in_valid_in(push_req),
    .in_data_in(push_value),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(read_done),
    .count_out(fifo_count)
  );

  // ----------------------------------------------------------------
  // block counting and data-available flag
  // ----------------------------------------------------------------
  wire [SIZE_W-1:0] blk_inc = SIZE_W'(blk_cnt_r + 1'b1);
  wire blk_hit = push_fire & (blk_inc >= size);
  wire fill_hit = ({2'h0, fifo_count} >= size);
  wire av_active = cr1_r[CR1_AV_TYPE] ? fill_hit : av_pulse_r;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      blk_cnt_r <= '0;
      av_pulse_r <= 1'b0;
      av_n_r <= 1'b1;
      overflow_r <= 1'b0;
    end else if (ce_in) begin
      av_pulse_r <= blk_hit & ~queue_clear;
      av_n_r <= ~av_active ^ cr1_r[CR1_AV_POL];
      // a drop in the clearing cycle still leaves the flag set
      overflow_r <= drop | (overflow_r & ~queue_clear);
      if (queue_clear) begin
        blk_cnt_r <= '0;
      end else if (blk_hit) begin
        blk_cnt_r <= '0;
      end else if (push_fire) begin
        blk_cnt_r <= blk_inc;
      end
    end
  end

  assign samples_waiting_n_out = av_n_r;
  assign overflow_out = overflow_r;

  // ----------------------------------------------------------------
  // bus read side, served whether asleep or not
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] bus_data_r;
  logic bus_oe_n_r;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      write_prev_r <= 1'b0;
      read_prev_r <= 1'b0;
      bus_data_r <= '0;
      bus_oe_n_r <= 1'b1;
    end else if (ce_in) begin
      write_prev_r <= write_strobe;
      read_prev_r <= read_strobe;
      if (read_begin) begin
        bus_data_r <= fifo_out_valid ? fifo_out_data : '0;
        bus_oe_n_r <= 1'b0;
      end else if (read_done) begin
        bus_oe_n_r <= 1'b1;
      end
    end
  end

  assign bus_data_out = bus_data_r;
  assign bus_data_oe_n_out = bus_oe_n_r;

endmodule // adcp_port

// ### adcp_fifo.sv
// Purpose: small first-in first-out store between the converter and the bus read side
// Assumes: one clock, synchronous active-high reset, clock enable freezes all state
// Notes: push when full and pop when empty are refused through the ready/valid flags
`timescale 1ns/100ps

module adcp_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 4,
  parameter int unsigned CNT_W = $clog2(DEPTH + 1)
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic clear_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic [CNT_W-1:0] count_out
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] count_r;
  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;
  wire [PTR_W-1:0] wr_ptr_nxt = (wr_ptr_r == PTR_LAST) ? '0 : PTR_W'(wr_ptr_r + 1'b1);
  wire [PTR_W-1:0] rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? '0 : PTR_W'(rd_ptr_r + 1'b1);

  assign in_ready_out = (count_r != CNT_FULL);
  assign out_valid_out = (count_r != '0);
  assign out_data_out = mem_r[rd_ptr_r];
  assign count_out = count_r;

  // ----------------------------------------------------------------
  // pointers and fill count
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (ce_in) begin
      if (clear_in) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
        count_r <= '0;
      end else begin
        if (push) begin
          wr_ptr_r <= wr_ptr_nxt;
        end
        if (pop) begin
          rd_ptr_r <= rd_ptr_nxt;
        end
        if (push & ~pop) begin
          count_r <= CNT_W'(count_r + 1'b1);
        end else if (pop & ~push) begin
          count_r <= CNT_W'(count_r - 1'b1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // storage, no reset needed since count guards every read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (ce_in & push & ~clear_in) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

endmodule // adcp_fifo

// ### adcp_port_assertions.sv
// Purpose: port-level checker for adcp_port
// Assumes: ce_in stays high while reset is applied
// Notes: strobe filtering delay is taken as three to five clocks
`timescale 1ns/100ps
module adcp_port_chk
  import adcp_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic bus_data_oe_n_out,
  input wire logic chip_select_low_active_n_in,
  input wire logic chip_select_high_active_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  input wire logic samples_waiting_n_out,
  input wire logic [2:0] analog_select_out,
  input wire logic hold_pulse_out,
  input wire logic ref_external_out,
  input wire logic sleep_request_out,
  input wire logic [1:0] check_sel_out,
  input wire logic output_code_format_out,
  input wire logic offset_enable_out,
  input wire logic rw_pin_mode_out,
  input wire logic overflow_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire logic rd_act = !chip_select_low_active_n_in && chip_select_high_active_in && !read_n_in;

  reset_state_a: assert property ($fell(srst_in) && $past(ce_in) |->
    !ref_external_out && !sleep_request_out && check_sel_out == 2'h0 && !overflow_out
    && bus_data_oe_n_out && samples_waiting_n_out) else $error("bad state after reset");
  read_drive_a: assert property ($fell(bus_data_oe_n_out) |-> $past(rd_act, 2))
    else $error("data driven without a read");
  read_idle_a: assert property (!rd_act [*6] |=> bus_data_oe_n_out)
    else $error("data still driven after read");
  cr0_hold_a: assert property (write_n_in [*8] |=>
    $stable({ref_external_out, sleep_request_out, check_sel_out})) else $error("cr0 moved");
  cr1_hold_a: assert property (write_n_in [*8] |=>
    $stable({output_code_format_out, offset_enable_out, rw_pin_mode_out}))
    else $error("cr1 moved");
  hold_once_a: assert property (hold_pulse_out |=> !hold_pulse_out)
    else $error("hold longer than a cycle");
  hold_awake_a: assert property (hold_pulse_out |-> !$past(sleep_request_out))
    else $error("hold while asleep");
  overflow_keep_a: assert property ((overflow_out && write_n_in) [*8] |=> overflow_out)
    else $error("overflow dropped");
  select_range_a: assert property (analog_select_out <= 3'h5)
    else $error("bad source code");

  hold_c: cover property (hold_pulse_out);
  avail_c: cover property ($fell(samples_waiting_n_out));
  ovf_c: cover property ($rose(overflow_out));
endmodule // adcp_port_chk

bind adcp_port adcp_port_chk adcp_port_chk_i (.*);

// ### adcp_host.sv
// Purpose: host processor model on the parallel bus
// Assumes: called just after a rising clock edge
// Notes: released data lines show the inverse of their last level (no pull)
`timescale 1ns/100ps
module adcp_host
  import adcp_pkg::*;
(
  input wire logic clk_in,
  input wire logic [DATA_W-1:0] bus_data_out,
  input wire logic bus_data_oe_n_out,
  output logic [DATA_W-1:0] bus_pin_out,
  output logic ra_lo_out,
  output logic ra_hi_out,
  output logic cs_n_out,
  output logic cs_hi_out,
  output logic rd_n_out,
  output logic wr_n_out
);
  logic drv_r = 1'b0;
  logic [DATA_W-1:0] val_r = 10'h000;
  logic [DATA_W-1:0] last_r = 10'h000;
  initial {ra_hi_out, ra_lo_out, cs_n_out, cs_hi_out, rd_n_out, wr_n_out} = 6'b001011;
  // only a driven level is remembered, so a released bus sits still at its inverse
  always @(posedge clk_in) if (drv_r || !bus_data_oe_n_out) last_r <= bus_pin_out;
  assign bus_pin_out = !bus_data_oe_n_out ? bus_data_out : (drv_r ? val_r : ~last_r);

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // selects, address and data stay put around the whole strobe
  task automatic wr(input logic [1:0] a, input logic [DATA_W-1:0] d);
    {ra_hi_out, ra_lo_out} <= a;
    val_r <= d;
    drv_r <= 1'b1;
    {cs_n_out, cs_hi_out, wr_n_out} <= 3'b010;
    idle(6);
    wr_n_out <= 1'b1;
    idle(6);
    drv_r <= 1'b0;
    {cs_n_out, cs_hi_out} <= 2'b10;
    idle(4);
  endtask

  // hi low breaks the select combination on purpose
  task automatic rd(input logic hi, output logic [DATA_W-1:0] d);
    {cs_n_out, cs_hi_out, rd_n_out} <= {1'b0, hi, 1'b0};
    for (int i = 0; i < 12 && bus_data_oe_n_out !== 1'b0; i++) @(negedge clk_in);
    d = (bus_data_oe_n_out === 1'b0) ? bus_data_out : 10'hxxx;
    @(posedge clk_in);
    rd_n_out <= 1'b1;
    for (int i = 0; i < 12 && bus_data_oe_n_out !== 1'b1; i++) @(negedge clk_in);
    @(posedge clk_in);
    {cs_n_out, cs_hi_out} <= 2'b10;
    idle(4);
  endtask
endmodule // adcp_host

// ### testbench.sv
// Purpose: self-checking bench for adcp_port
// Assumes: host model does all bus cycles
// Notes: status word packs the control outputs for compact compares
`timescale 1ns/100ps
module testbench
  import adcp_pkg::*;
();
  logic clk_in, srst_in, ce_in, sclk, oe_n, ra_lo, ra_hi, cs_n, cs_hi, rd_n, wr_n;
  logic sw_n, hold, ref_x, sleep, fmt, ofs, rwm, ovf;
  logic [DATA_W-1:0] samp, pin, dout, got;
  logic [1:0] chk;
  logic [2:0] sel;
  int err_total = 0;
  int n_tests = 0;
  int n_av = 0;
  int n_hold = 0;
  logic [DATA_W-1:0] tv [4] = '{10'h155, CODE_UPPER, CODE_MID, CODE_LOWER};
  wire logic [9:0] stat = {oe_n, ref_x, sleep, chk, fmt, ofs, rwm, ovf, sw_n};

  adcp_port adcp_port_i (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .bus_data_in(pin), .bus_data_out(dout), .bus_data_oe_n_out(oe_n),
    .reg_addr_bit_lo_in(ra_lo), .reg_addr_bit_hi_in(ra_hi),
    .chip_select_low_active_n_in(cs_n), .chip_select_high_active_in(cs_hi),
    .read_n_in(rd_n), .write_n_in(wr_n), .sample_clock_in(sclk),
    .samples_waiting_n_out(sw_n), .sample_value_in(samp), .analog_select_out(sel),
    .hold_pulse_out(hold), .ref_external_out(ref_x), .sleep_request_out(sleep),
    .check_sel_out(chk), .output_code_format_out(fmt), .offset_enable_out(ofs),
    .rw_pin_mode_out(rwm), .overflow_out(ovf));
  adcp_host adcp_host_i (.clk_in(clk_in), .bus_data_out(dout), .bus_data_oe_n_out(oe_n),
    .bus_pin_out(pin), .ra_lo_out(ra_lo), .ra_hi_out(ra_hi), .cs_n_out(cs_n),
    .cs_hi_out(cs_hi), .rd_n_out(rd_n), .wr_n_out(wr_n));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // counted on the falling edge so register updates have landed
  always @(negedge clk_in) begin
    if (sw_n === 1'b0) n_av++;
    if (hold === 1'b1) n_hold++;
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // edges slower than the pin filter, so none are missed
  task automatic edges(input int n);
    repeat (n) begin
      sclk <= 1'b0;
      repeat (4) @(posedge clk_in);
      sclk <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
    adcp_host_i.idle(4);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {srst_in, ce_in, sclk} = 3'b111;
    samp = 10'h155;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    adcp_host_i.idle(2);
    check(stat, 10'h201);
    adcp_host_i.rd(1'b1, got);
    check(got, 10'h000);
    for (int k = 0; k < 4; k++) begin
      adcp_host_i.wr(ADDR_CR0, {k[1:0], 8'h25});
      check(stat, {3'b111, k[1:0], 5'h01});
    end
    adcp_host_i.wr(2'h2, 10'h000);
    adcp_host_i.wr(2'h3, 10'h000);
    check(stat, 10'h3E1);
    adcp_host_i.wr(ADDR_CR1, 10'h1C0);
    check(stat, 10'h3FD);
    adcp_host_i.wr(ADDR_CR1, 10'h001);
    check(stat, 10'h201);
    adcp_host_i.wr(ADDR_CR0, 10'h120);
    adcp_host_i.wr(ADDR_CR1, 10'h006);
    edges(12);
    adcp_host_i.rd(1'b1, got);
    check(got, 10'h000);
    edges(3);
    check(10'(n_av), 10'h000);
    edges(1);
    check(10'(n_av), 10'h001);
    for (int i = 0; i < 4; i++) begin
      adcp_host_i.rd(1'b1, got);
      check(got, CODE_UPPER);
    end
    edges(1);
    adcp_host_i.rd(1'b0, got);
    adcp_host_i.rd(1'b1, got);
    check(got, CODE_UPPER);
    edges(5);
    check(stat, 10'h223);
    adcp_host_i.wr(ADDR_CR1, 10'h006);
    check(stat, 10'h221);
    adcp_host_i.wr(ADDR_CR0, 10'h126);
    edges(1);
    adcp_host_i.rd(1'b1, got);
    check(got, 10'h000);
    for (int k = 0; k < 4; k++) begin
      adcp_host_i.wr(ADDR_CR0, {k[1:0], 8'h22});
      edges(1);
      adcp_host_i.rd(1'b1, got);
      check(got, tv[k]);
    end
    check(10'(n_hold), 10'h004);
    adcp_host_i.wr(ADDR_CR0, 10'h08A);
    edges(1);
    for (int i = 0; i < 3; i++) begin
      adcp_host_i.rd(1'b1, got);
      check(got, (i < 2) ? samp : 10'h000);
    end
    adcp_host_i.wr(ADDR_CR0, 10'h01A);
    check(10'(sel), 10'h003);
    adcp_host_i.wr(ADDR_CR1, 10'h010);
    check(stat, 10'h201);
    edges(1);
    check(stat, 10'h200);
    adcp_host_i.wr(ADDR_CR1, 10'h030);
    check(stat, 10'h201);
    results;
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    err_total++;
    results;
  end
endmodule // testbench
